// [src/ipf_pkg.sv]
// shared constants for the interleaved pfc pwm and conversion trigger block
package ipf_pkg;

  // ==========================================================
  // clocking and time base
  localparam int SYS_CLK_HZ   = 60000000;               // time base tick rate
  localparam int PWM_FREQ_HZ  = 200000;                 // switching frequency
  localparam int PWM_TICKS    = SYS_CLK_HZ / PWM_FREQ_HZ; // ticks per period (300)
  localparam int CNT_W        = 8;
  localparam logic [CNT_W-1:0] PRD_VALUE = CNT_W'(PWM_TICKS / 2); // up-down peak 150
  localparam int NUM_TB       = 4;

  // ==========================================================
  // event rates
  localparam int FAST_HZ      = 100000;
  localparam int VLOOP_HZ     = 50000;
  localparam int SLOW_HZ      = 10000;
  localparam logic [4:0] SLOW_DIV = 5'(PWM_FREQ_HZ / SLOW_HZ); // periods per slow event

  // ==========================================================
  // auxiliary compare values, time base index 0..3 in 8-bit lanes
  localparam logic [NUM_TB*CNT_W-1:0] TB_CMPA = {8'h14, 8'h00, 8'h28, 8'h00};
  localparam logic [NUM_TB*CNT_W-1:0] TB_COMPARE_B_VALUE = {8'h46, 8'h3c, 8'h50, 8'h00};
  localparam int NUM_SOC      = 8;
  localparam int AVG_N        = 8;
  localparam int AVG_SHIFT    = 3;

  // ==========================================================
  // sample formats
  localparam int ADC_W        = 12;
  localparam int Q_W          = 32;
  localparam int Q_FRAC       = 24;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DUTY   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_OVP    = 8'h0c;
  localparam logic [7:0] REG_IAVG   = 8'h10;
  localparam logic [7:0] REG_VRECT  = 8'h14;
  localparam logic [7:0] REG_VBUS   = 8'h18;

  // field positions and reset values
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_BUILD_LSB = 2;
  localparam logic [1:0] BUILD_RESET = 2'h1;
  localparam logic [ADC_W-1:0] OVP_RESET = 12'he00;
  localparam int STAT_TRIP_BIT  = 0;
  localparam int STAT_POS_BIT   = 1;
  localparam int STAT_DIR_BIT   = 2;
  localparam int STAT_CNT_LSB   = 16;

endpackage

// [src/ipf_timebase.sv]
// up-down time base counter with zero, period and compare events
`timescale 1ns/1ps
module ipf_timebase
  import ipf_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] cmpa,
  input  wire logic [W-1:0] compare_b_value,
  output logic      [W-1:0] count,
  output logic              dir_down,
  output logic              ev_zero,
  output logic              ev_prd,
  output logic              ev_cmpa_up,
  output logic              ev_cmpa_dn,
  output logic              ev_compare_b_value_up
);

  // ==========================================================
  // counter: reverse at period and at zero
  logic [W-1:0] next_count;
  logic         next_dir;
  wire          at_prd  = (count == period);
  wire          at_zero = (count == '0);

  always_comb begin
    next_count = count;
    next_dir   = dir_down;
    if (!run) begin
      next_count = '0;
      next_dir   = 1'b0;
    end else if (!dir_down) begin
      if (at_prd) begin
        next_dir   = 1'b1;                  // R20
        next_count = count - 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end else if (at_zero) begin
      next_dir   = 1'b0;                    // R20
      next_count = count + 1'b1;
    end else begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= '0;
      dir_down <= 1'b0;
    end else begin
      count    <= next_count;               // R2 R3
      dir_down <= next_dir;
    end
  end

  // ==========================================================
  // event decode, each one tick wide per pass
  assign ev_zero    = run & at_zero;
  assign ev_prd     = run & at_prd;
  assign ev_cmpa_up = run & !dir_down & (count == cmpa);
  assign ev_cmpa_dn = run & dir_down & (count == cmpa);
  assign ev_compare_b_value_up = run & !dir_down & (count == compare_b_value);

  chk_peak_turn: assert property (@(posedge clk) disable iff (!rst_n) // R20
    run && at_prd && !dir_down |=> run -> (count == period - 1'b1) && dir_down)
    else $error("time base did not turn at period");

endmodule

// [src/ipf_sample_avg.sv]
// current sample scaling to q24 and eight-sample average
`timescale 1ns/1ps
module ipf_sample_avg
  import ipf_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             sample_valid,
  input  wire logic [ADC_W-1:0] sample,
  output logic      [Q_W-1:0]   avg_q24,
  output logic                  avg_done
);

  // ==========================================================
  // accumulate eight results, then divide by shifting
  logic [ADC_W+AVG_SHIFT-1:0] acc;
  logic [AVG_SHIFT-1:0]       idx;
  wire  [ADC_W+AVG_SHIFT-1:0] sum_now = acc + (AVG_SHIFT+ADC_W)'(sample);
  wire                        last    = (idx == AVG_SHIFT'(AVG_N - 1));
  wire  [ADC_W-1:0]           mean    = sum_now[ADC_W+AVG_SHIFT-1:AVG_SHIFT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc      <= '0;
      idx      <= '0;
      avg_q24  <= '0;
      avg_done <= 1'b0;
    end else begin
      avg_done <= sample_valid & last;
      if (sample_valid) begin
        idx <= idx + 1'b1;
        acc <= last ? '0 : sum_now;
        if (last) begin
          avg_q24 <= {{(Q_W-Q_FRAC){1'b0}}, mean, {(Q_FRAC-ADC_W){1'b0}}}; // R7 R13
        end
      end
    end
  end

  chk_avg_format: assert property (@(posedge clk) disable iff (!rst_n) // R13
    avg_done |-> avg_q24[Q_W-1:Q_FRAC] == '0 && avg_q24[Q_FRAC-ADC_W-1:0] == '0)
    else $error("average not in q24 form");

  chk_avg_eight: assert property (@(posedge clk) disable iff (!rst_n) // R6 R7
    avg_done |-> $past(idx) == AVG_SHIFT'(AVG_N - 1) && $past(sample_valid))
    else $error("average closed on wrong sample count");

  cov_avg_done: cover property (@(posedge clk) disable iff (!rst_n) avg_done);

endmodule

// [src/ipf_pwm_top.sv]
// interleaved pfc gate drive, conversion triggers, event rates and apb registers
`timescale 1ns/1ps
// Summary of operation
// (R1) gate drive switches at 200 kHz
// (R2) one count per clock, 300 per period
// (R3) up-down base with peak 150
// (R4) output A drives switch one, B two
// (R5) current conversion at each on-pulse middle
// (R6) eight current samples per 10 us window; the triggers give seven current samples plus one dummy per 5 us period
// (R7) eight samples averaged for current loop
// (R8) voltage conversions start while switch is on
// (R9) four time bases make all triggers
// (R10) fast event at half the pwm rate
// (R11) 10 kHz slow event, fast event preempts
// (R12) current loop 100 kHz, voltage loop 50 kHz
// (R13) 12-bit results become q24 32-bit values
// (R14) detect half cycle, make rectified voltage
// (R15) operator picks build stage 1, 2 or 3; the two-bit field also accepts 0 and is only stored and read back
// (R16) second phase shifted 180 degrees
// (R17) fast event on base two compare-b up
// (R18) shadow duty loads at main zero
// (R19) bus overvoltage forces outputs low till reset
// (R20) counter turns at period and at zero
module ipf_pwm_top
  import ipf_pkg::*;
#(
  parameter logic [ADC_W-1:0] OVP_CODE_DEF = OVP_RESET
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             cur_valid,
  input  wire logic [ADC_W-1:0] cur_sample,
  input  wire logic             volt_valid,
  input  wire logic [ADC_W-1:0] line_voltage_sense,
  input  wire logic [ADC_W-1:0] neutral_voltage_sense,
  input  wire logic [ADC_W-1:0] bus_voltage_sense,
  output logic                  phase_one_gate_out,
  output logic                  phase_two_gate_out,
  output logic      [NUM_SOC-1:0] soc_trig,
  output logic                  fast_control_event,
  output logic                  voltage_loop_event,
  output logic                  slow_measure_event,
  output logic                  positive_half,
  output logic      [CNT_W-1:0] main_timebase_count
);

  // ==========================================================
  // register state
  logic             run;
  logic [1:0]       build_stage_select;
  logic [CNT_W-1:0] duty_shadow;
  logic [CNT_W-1:0] duty_act;
  logic [ADC_W-1:0] ovp_code;
  logic             trip;
  logic [Q_W-1:0]   vrect_q24;
  logic [Q_W-1:0]   vbus_q24;
  logic [Q_W-1:0]   iavg_q24;
  logic             avg_done;

  // ==========================================================
  // four time bases
  logic [NUM_TB*CNT_W-1:0] aux_timebase_counts;
  logic [NUM_TB-1:0] tb_dir, tb_zero, tb_prd, tb_au, tb_ad, tb_bu;

  genvar g;
  generate
    for (g = 0; g < NUM_TB; g++) begin : g_tb
      ipf_timebase #(.W(CNT_W)) u_tb (       // R9
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (run),
        .period     (PRD_VALUE),            // R1 R3
        .cmpa       (TB_CMPA[g*CNT_W +: CNT_W]),
        .compare_b_value       (TB_COMPARE_B_VALUE[g*CNT_W +: CNT_W]),
        .count      (aux_timebase_counts[g*CNT_W +: CNT_W]),
        .dir_down   (tb_dir[g]),
        .ev_zero    (tb_zero[g]),
        .ev_prd     (tb_prd[g]),
        .ev_cmpa_up (tb_au[g]),
        .ev_cmpa_dn (tb_ad[g]),
        .ev_compare_b_value_up (tb_bu[g])
      );
    end
  endgenerate

  assign main_timebase_count = aux_timebase_counts[CNT_W-1:0];
  wire main_zero = tb_zero[0];

  // ==========================================================
  // shadow duty transfer at main zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_act <= '0;
    end else if (main_zero) begin
      duty_act <= duty_shadow;              // R18
    end
  end

  // ==========================================================
  // gate drive: A centred on zero, B centred on period
  wire gate_ok     = run & !trip;
  wire next_gate_a = gate_ok & (main_timebase_count < duty_act);           // R4 R5
  wire next_gate_b = gate_ok & (main_timebase_count > PRD_VALUE - duty_act); // R16

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_one_gate_out <= 1'b0;
      phase_two_gate_out <= 1'b0;
    end else begin
      phase_one_gate_out <= next_gate_a;    // R4 R19
      phase_two_gate_out <= next_gate_b;    // R4 R19
    end
  end

  // ==========================================================
  // start-of-conversion triggers; 4 is the dummy conversion
  wire [NUM_SOC-1:0] next_soc = {tb_bu[3], tb_au[3], tb_bu[2], tb_zero[2],
                                 tb_ad[1], tb_au[1], tb_prd[0], tb_zero[0]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soc_trig <= '0;
    end else begin
      soc_trig <= gate_ok ? next_soc : '0;  // R5 R6 R8 R9
    end
  end

  // ==========================================================
  // event rates: fast every second base-two compare-b match
  logic       fast_phase;
  logic       vloop_phase;
  logic [4:0] slow_cnt;
  logic       slow_pending;
  // slow tick shares the base-two match, so a clash with the fast event defers it
  wire        fast_hit  = tb_bu[1] & fast_phase;                 // R17
  wire        slow_tick = tb_bu[1] & (slow_cnt == SLOW_DIV - 5'h1);
  wire        slow_want = slow_tick | slow_pending;
  wire        slow_fire = slow_want & !fast_hit;                 // R11

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_phase         <= 1'b0;
      vloop_phase        <= 1'b0;
      slow_cnt           <= '0;
      slow_pending       <= 1'b0;
      fast_control_event <= 1'b0;
      voltage_loop_event <= 1'b0;
      slow_measure_event <= 1'b0;
    end else begin
      if (tb_bu[1]) fast_phase <= !fast_phase;                   // R10
      if (fast_hit) vloop_phase <= !vloop_phase;                 // R12
      if (tb_bu[1]) slow_cnt <= slow_tick ? '0 : slow_cnt + 5'h1;
      slow_pending       <= slow_want & fast_hit;                // R11
      fast_control_event <= fast_hit;                            // R10 R12
      voltage_loop_event <= fast_hit & vloop_phase;              // R12
      slow_measure_event <= slow_fire;                           // R11
    end
  end

  // ==========================================================
  // voltage samples: polarity, rectification, q24 scaling
  wire              line_hi  = line_voltage_sense >= neutral_voltage_sense;
  wire [ADC_W-1:0]  rect_raw = line_hi ? line_voltage_sense - neutral_voltage_sense
                                       : neutral_voltage_sense - line_voltage_sense;
  localparam int PAD_HI = Q_W - Q_FRAC;
  localparam int PAD_LO = Q_FRAC - ADC_W;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      positive_half <= 1'b0;
      vrect_q24     <= '0;
      vbus_q24      <= '0;
    end else if (volt_valid) begin
      positive_half <= line_hi;                                          // R14
      vrect_q24     <= {{PAD_HI{1'b0}}, rect_raw, {PAD_LO{1'b0}}};        // R13 R14
      vbus_q24      <= {{PAD_HI{1'b0}}, bus_voltage_sense, {PAD_LO{1'b0}}}; // R13
    end
  end

  // ==========================================================
  // overvoltage trip, cleared only by reset
  wire ov_seen = volt_valid & (bus_voltage_sense > ovp_code);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip <= 1'b0;
    end else if (ov_seen) begin
      trip <= 1'b1;                         // R19
    end
  end

  // ==========================================================
  // current oversampling average
  ipf_sample_avg u_avg (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample_valid (cur_valid),
    .sample       (cur_sample),
    .avg_q24      (iavg_q24),               // R7
    .avg_done     (avg_done)
  );

  // ==========================================================
  // apb slave: read data captured in setup, ready in access
  wire setup    = psel & !penable;
  wire access   = psel & penable;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_duty = (paddr == REG_DUTY);
  wire hit_stat = (paddr == REG_STATUS);
  wire hit_ovp  = (paddr == REG_OVP);
  wire hit_iavg = (paddr == REG_IAVG);
  wire hit_vrec = (paddr == REG_VRECT);
  wire hit_vbus = (paddr == REG_VBUS);
  wire mapped   = hit_ctrl | hit_duty | hit_stat | hit_ovp | hit_iavg | hit_vrec | hit_vbus;
  wire wr_en    = access & pwrite & mapped;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[CTRL_RUN_BIT] = run;
      rd_mux[CTRL_BUILD_LSB +: 2] = build_stage_select;
    end
    if (hit_duty) rd_mux[CNT_W-1:0] = duty_shadow;
    if (hit_stat) begin
      rd_mux[STAT_TRIP_BIT] = trip;
      rd_mux[STAT_POS_BIT]  = positive_half;
      rd_mux[STAT_DIR_BIT]  = tb_dir[0];
      rd_mux[STAT_CNT_LSB +: CNT_W] = main_timebase_count;
    end
    if (hit_ovp)  rd_mux[ADC_W-1:0] = ovp_code;
    if (hit_iavg) rd_mux = iavg_q24;
    if (hit_vrec) rd_mux = vrect_q24;
    if (hit_vbus) rd_mux = vbus_q24;
  end

  assign pready  = access;
  assign pslverr = access & !mapped;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setup & !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // register writes take effect at the access edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run                <= 1'b0;
      build_stage_select <= BUILD_RESET;
      duty_shadow        <= '0;
      ovp_code           <= OVP_CODE_DEF;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        run                <= pwdata[CTRL_RUN_BIT];
        build_stage_select <= pwdata[CTRL_BUILD_LSB +: 2];  // R15
      end
      if (hit_duty) duty_shadow <= pwdata[CNT_W-1:0];
      if (hit_ovp)  ovp_code    <= pwdata[ADC_W-1:0];
    end
  end

  // ==========================================================
  // checks; fast_gap saturates until the first fast event after run rises
  logic [9:0] fast_gap;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fast_gap <= 10'h3ff;
    else if (!run) fast_gap <= 10'h3ff;
    else if (fast_control_event) fast_gap <= '0;
    else if (fast_gap != 10'h3ff) fast_gap <= fast_gap + 10'h1;
  end

  chk_period_span: assert property (@(posedge clk) disable iff (!rst_n || !run) // R2 R3
    main_zero |-> ##300 (main_timebase_count == '0))
    else $error("pwm period is not 300 ticks");

  chk_fast_rate: assert property (@(posedge clk) disable iff (!rst_n) // R10
    fast_control_event && fast_gap != 10'h3ff |->
      fast_gap == 10'(2 * PWM_TICKS - 1))
    else $error("fast event spacing is not two periods");

  chk_fast_source: assert property (@(posedge clk) disable iff (!rst_n) // R17
    fast_control_event |-> $past(tb_bu[1]) && $past(aux_timebase_counts[2*CNT_W-1:CNT_W])
      == TB_COMPARE_B_VALUE[2*CNT_W-1:CNT_W])
    else $error("fast event not from base two compare-b");

  chk_slow_yield: assert property (@(posedge clk) disable iff (!rst_n) // R11
    slow_tick && fast_hit |=> !slow_measure_event ##1 slow_measure_event)
    else $error("slow event not deferred behind fast event");

  chk_shadow_load: assert property (@(posedge clk) disable iff (!rst_n) // R18
    $changed(duty_act) |-> $past(main_zero))
    else $error("active duty changed away from zero");

  chk_trip_hold: assert property (@(posedge clk) disable iff (!rst_n) // R19
    trip |=> trip && !phase_one_gate_out && !phase_two_gate_out)
    else $error("gates not held low after trip");

  chk_gate_mid: assert property (@(posedge clk) disable iff (!rst_n) // R4 R5
    soc_trig[0] && $past(duty_act) != '0 |-> phase_one_gate_out)
    else $error("current conversion outside phase one on time");

  chk_iavg_update: assert property (@(posedge clk) disable iff (!rst_n) // R7
    $changed(iavg_q24) |-> avg_done)
    else $error("current average changed without eight samples");

  chk_phase_two: assert property (@(posedge clk) disable iff (!rst_n) // R16
    soc_trig[1] && duty_act != '0 |-> phase_two_gate_out && !phase_one_gate_out ||
      duty_act > PRD_VALUE / 2)
    else $error("phase two not centred on period");

  chk_rect_sign: assert property (@(posedge clk) disable iff (!rst_n) // R14
    $past(volt_valid) |-> positive_half ==
      ($past(line_voltage_sense) >= $past(neutral_voltage_sense)))
    else $error("half cycle polarity wrong");

  cov_fast_event: cover property (@(posedge clk) disable iff (!rst_n) fast_control_event);
  cov_vloop_event: cover property (@(posedge clk) disable iff (!rst_n) voltage_loop_event);
  cov_slow_event: cover property (@(posedge clk) disable iff (!rst_n) slow_measure_event);
  cov_trip: cover property (@(posedge clk) disable iff (!rst_n) $rose(trip));

endmodule

// [verif/ipf_adc_model.sv]
// behavioural model of the sensing converter
`timescale 1ns/1ps
module ipf_adc_model
  import ipf_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [NUM_SOC-1:0] soc_trig,
  input  wire logic [ADC_W-1:0]   cur_code,
  input  wire logic [ADC_W-1:0]   vl,
  input  wire logic [ADC_W-1:0]   vn,
  input  wire logic [ADC_W-1:0]   vb,
  output logic                    cur_valid,
  output logic      [ADC_W-1:0]   cur_sample,
  output logic                    volt_valid,
  output logic      [ADC_W-1:0]   line_v,
  output logic      [ADC_W-1:0]   neut_v,
  output logic      [ADC_W-1:0]   bus_v
);
  // =========================
  // conversion latency pipes
  logic [3:0] cur_sh;
  logic [3:0] volt_sh;

  // current on every trigger but the dummy one, voltages at the period trigger
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_sh  <= 4'h0;
      volt_sh <= 4'h0;
    end else begin
      cur_sh  <= {cur_sh[2:0], |{soc_trig[7:5], soc_trig[3:0]}};
      volt_sh <= {volt_sh[2:0], soc_trig[1]};
    end
  end

  // result lines show inverted data outside their valid cycle
  assign cur_valid  = cur_sh[LAT];
  assign volt_valid = volt_sh[LAT];
  assign cur_sample = cur_valid ? cur_code : ~cur_code;
  assign line_v     = volt_valid ? vl : ~vl;
  assign neut_v     = volt_valid ? vn : ~vn;
  assign bus_v      = volt_valid ? vb : ~vb;
endmodule

// [verif/tb.sv]
// self-checking bench for the interleaved pfc pwm block
`timescale 1ns/1ps
module tb;
  import ipf_pkg::*;
  logic               clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               cur_valid, volt_valid, ga, gb, fast, vloop, slow, pos;
  logic [ADC_W-1:0]   cur_sample, line_v, neut_v, bus_v, cur_code, vl, vn, vb;
  logic [NUM_SOC-1:0] soc;
  logic [CNT_W-1:0]   cnt;
  int                 errors, checks, n_a, n_b, n_f, n_v, n_s, n_z, n_t, n_m;

  ipf_pwm_top ipf_pwm_top_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cur_valid, .cur_sample, .volt_valid,
    .line_voltage_sense(line_v), .neutral_voltage_sense(neut_v), .bus_voltage_sense(bus_v),
    .phase_one_gate_out(ga), .phase_two_gate_out(gb), .soc_trig(soc),
    .fast_control_event(fast), .voltage_loop_event(vloop), .slow_measure_event(slow),
    .positive_half(pos), .main_timebase_count(cnt));

  ipf_adc_model ipf_adc_model_i (.clk, .rst_n, .soc_trig(soc), .cur_code, .vl, .vn, .vb,
    .cur_valid, .cur_sample, .volt_valid, .line_v, .neut_v, .bus_v);

  // =========================
  // shared tasks
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask

  // counts output activity over n cycles
  task automatic measure(input int n);
    n_a = 0; n_b = 0; n_f = 0; n_v = 0; n_s = 0; n_z = 0; n_t = 0; n_m = 0;
    repeat (n) begin
      @(posedge clk);
      n_a += int'(ga === 1'b1); n_b += int'(gb === 1'b1); n_f += int'(fast === 1'b1);
      n_v += int'(vloop === 1'b1); n_s += int'(slow === 1'b1); n_z += int'(cnt === 8'h00);
      n_t += $countones(soc);
      if (int'(cnt) > n_m) n_m = int'(cnt);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // =========================
  // test sequence
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; cur_code = 12'h123; vl = 12'h300; vn = 12'h100; vb = 12'h400;
    errors = 0; checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl reset", REG_CTRL, 32'(BUILD_RESET) << CTRL_BUILD_LSB);
    rdchk("ovp reset", REG_OVP, 32'(OVP_RESET));
    rdchk("duty reset", REG_DUTY, 32'h0);
    rdchk("status reset", REG_STATUS, 32'h0);
    apb(1'b1, 8'h1c, 32'hffffffff);
    cmp("unmapped write err", 32'h1, 32'(err));
    rdchk("unmapped read", 8'h1c, 32'h0);
    cmp("unmapped read err", 32'h1, 32'(err));
    for (int b = 1; b <= 3; b++) begin
      apb(1'b1, REG_CTRL, 32'(b) << CTRL_BUILD_LSB);
      rdchk("build stage", REG_CTRL, 32'(b) << CTRL_BUILD_LSB);
    end
    $display("test registers done");
    apb(1'b1, REG_DUTY, 32'd60);
    apb(1'b1, REG_CTRL, 32'h1);
    measure(600);
    measure(1200);
    cmp("period zeros", 32'd4, 32'(n_z));
    cmp("peak count", 32'(PRD_VALUE), 32'(n_m));
    cmp("gate a on", 32'd476, 32'(n_a));
    cmp("gate b on", 32'd476, 32'(n_b));
    cmp("triggers", 32'd32, 32'(n_t));
    cmp("fast events", 32'd2, 32'(n_f));
    cmp("vloop events", 32'd1, 32'(n_v));
    rdchk("current avg", REG_IAVG, 32'(cur_code) << 12);
    rdchk("bus q24", REG_VBUS, 32'(vb) << 12);
    rdchk("rectified", REG_VRECT, 32'h00200000);
    cmp("positive half", 32'h1, 32'(pos));
    $display("test pwm run done");
    apb(1'b1, REG_DUTY, 32'd20);
    vl <= 12'h100;
    vn <= 12'h300;
    measure(600);
    measure(6000);
    cmp("gate a short", 32'd780, 32'(n_a));
    cmp("slow events", 32'd1, 32'(n_s));
    cmp("negative half", 32'h0, 32'(pos));
    rdchk("rectified neg", REG_VRECT, 32'h00200000);
    $display("test duty and rates done");
    vb <= 12'hf00;
    measure(600);
    measure(600);
    cmp("trip gates", 32'h0, 32'(n_a + n_b));
    apb(1'b0, REG_STATUS, 32'h0);
    cmp("trip flag", 32'h1, 32'(rd[STAT_TRIP_BIT]));
    vb <= 12'h400;
    measure(600);
    cmp("trip sticky", 32'h0, 32'(n_a + n_b));
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("status after reset", REG_STATUS, 32'h0);
    $display("test overvoltage done");
    tally_and_finish();
  end
endmodule
